//--- core/dfs_pkg.sv
// Purpose: Shared constants for the drive fault supervisor.
// Assumes: 100 MHz core clock and a 32-bit Avalon-MM register port.
// Notes: Byte offsets are word aligned; all programmed times count 1 ms ticks.
package dfs_pkg;
  // Clock and time base.
  localparam int CLK_HZ = 100_000_000;
  localparam int TICK_MS = 1;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  // Panel link windows, in milliseconds (one tick each).
  localparam int PANEL_START_MS = 5000;
  localparam int PANEL_LOSS_MS = 2000;
  localparam int PANEL_START_TICKS = PANEL_START_MS / TICK_MS;
  localparam int PANEL_LOSS_TICKS = PANEL_LOSS_MS / TICK_MS;
  // Register byte offsets.
  localparam logic [7:0] OFS_MODE_CFG = 8'h00;
  localparam logic [7:0] OFS_TERM_FUNC_LO = 8'h04;
  localparam logic [7:0] OFS_TERM_FUNC_HI = 8'h08;
  localparam logic [7:0] OFS_ENC_TIME = 8'h0C;
  localparam logic [7:0] OFS_DEV_LEVEL = 8'h10;
  localparam logic [7:0] OFS_DEV_TIME = 8'h14;
  localparam logic [7:0] OFS_HOST_TIME = 8'h18;
  localparam logic [7:0] OFS_FB_LEVEL = 8'h1C;
  localparam logic [7:0] OFS_FB_TIME = 8'h20;
  localparam logic [7:0] OFS_HOST_CMD = 8'h24;
  localparam logic [7:0] OFS_FAULT_STATUS = 8'h28;
  localparam logic [7:0] OFS_FAULT_RESET = 8'h2C;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h30;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h34;
  // Mode configuration fields.
  localparam int CFG_MODE_LSB = 0;
  localparam int CFG_DEV_ACT_LSB = 4;
  localparam int CFG_HOST_ACT_LSB = 8;
  localparam int CFG_FB_ACT_LSB = 12;
  localparam int CFG_SAFE_STOP_BIT = 16;
  localparam int CFG_EXT_SEL_LSB = 17;
  localparam int CFG_LED_PANEL_BIT = 20;
  localparam logic [31:0] CFG_MASK = 32'h00173337;
  // Decoded setting values.
  localparam logic [2:0] MODE_VF_ENC = 3'h1;
  localparam logic [2:0] MODE_SV_A = 3'h3;
  localparam logic [2:0] MODE_SV_B = 3'h4;
  localparam logic [1:0] HOST_ACT_MAX = 2'h2;
  localparam logic [1:0] FB_ACT_FAULT = 2'h2;
  localparam logic [7:0] FUNC_EXT_FAULT = 8'h19;
  localparam logic [7:0] FUNC_SAFE_STOP = 8'h3A;
  localparam int HOST_CMD_EXT_BIT = 2;
  localparam int FAULT_RESET_BIT = 0;
  // Fault bit positions in status, interrupt status and mask.
  localparam int FLT_ENC = 0;
  localparam int FLT_DEV = 1;
  localparam int FLT_HOST = 2;
  localparam int FLT_FB = 3;
  localparam int FLT_STO = 4;
  localparam int FLT_SAFE_STOP = 5;
  localparam int FLT_HOST_EXT = 6;
  localparam int FLT_PANEL_START = 7;
  localparam int FLT_PANEL_LOSS = 8;
  localparam int FLT_TERM_LSB = 16;
  localparam int FLT_W = 24;
  localparam logic [FLT_W-1:0] FLT_VALID = 24'hFF01FF;
  // Reset values.
  localparam logic [31:0] RST_MODE_CFG = 32'h00000000;
  localparam logic [31:0] RST_TERM_FUNC = 32'h00000000;
  localparam logic [15:0] RST_ENC_TIME = 16'h03E8;
  localparam logic [15:0] RST_DEV_LEVEL = 16'hFFFF;
  localparam logic [15:0] RST_DEV_TIME = 16'h03E8;
  localparam logic [15:0] RST_HOST_TIME = 16'h03E8;
  localparam logic [15:0] RST_FB_LEVEL = 16'h0000;
  localparam logic [15:0] RST_FB_TIME = 16'h03E8;
endpackage

//--- core/dfs_timer_if.sv
// Purpose: Carries one detection window between the supervisor and a timer.
// Assumes: Limit is in ticks of the shared millisecond enable.
// Notes: The owner drives condition and limit; the timer answers expired.
`timescale 1ns/100ps
interface dfs_timer_if #(parameter int W = 16);
  logic cond;
  logic [W-1:0] limit;
  logic expired;
  modport timer (input cond, input limit, output expired);
  modport owner (output cond, output limit, input expired);
endinterface

//--- core/dfs_window_timer.sv
// Purpose: Counts ticks while a condition holds and flags the window end.
// Assumes: Tick is a one-cycle enable pulse.
// Notes: The count saturates, so an all-ones limit in strict mode never expires.
`timescale 1ns/100ps
module dfs_window_timer #(
  parameter int W = 16,
  parameter bit STRICT = 1'b0
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic resetn,
  // Time base.
  input wire logic tick,
  // Window handshake.
  dfs_timer_if.timer win
);
  logic [W-1:0] count_r;

  // The count restarts as soon as the condition drops, so brief gaps never add up.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      count_r <= '0;
    end else if (!win.cond) begin
      count_r <= '0;
    end else if (tick && (count_r != {W{1'b1}})) begin
      count_r <= count_r + 1'b1;
    end
  end

  // Strict mode demands the limit be exceeded, not merely reached.
  assign win.expired = win.cond && (STRICT ? (count_r > win.limit) : (count_r >= win.limit));
endmodule

//--- core/dfs_supervisor.sv
// Purpose: Drive fault supervisor with detection windows and latched fault status.
// Assumes: All inputs are synchronous to core_clk; panel and host frame strobes are one cycle.
// Notes: Registers sit on Avalon-MM; every access takes one wait state.
`timescale 1ns/100ps

module dfs_supervisor
  import dfs_pkg::*;
#(
  parameter int TICK_DIV = dfs_pkg::TICK_CYCLES,
  parameter int PANEL_START = dfs_pkg::PANEL_START_TICKS,
  parameter int PANEL_LOSS = dfs_pkg::PANEL_LOSS_TICKS
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic resetn,
  // Avalon-MM register slave.
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Encoder and speed.
  input wire logic encoderPulse,
  input wire logic [15:0] speedValue,
  // Host link and process feedback.
  input wire logic hostFrameValid,
  input wire logic [15:0] feedbackValue,
  // Safety and terminal inputs.
  input wire logic safetyInputA,
  input wire logic safetyInputB,
  input wire logic [7:0] terminalIn,
  // Operator panel link.
  input wire logic panelRxValid,
  // Drive stop and fault logic.
  output logic faultActive,
  output logic [4:0] faultCode,
  output logic motorStop,
  output logic panelDisplayLit,
  output logic irq
);
  import dfs_pkg::*;

  localparam int DIV_W = $clog2(TICK_DIV + 1);

  logic [31:0] modeCfg_r;
  logic [31:0] termFuncLo_r;
  logic [31:0] termFuncHi_r;
  logic [15:0] encTime_r;
  logic [15:0] devLevel_r;
  logic [15:0] devTime_r;
  logic [15:0] hostTime_r;
  logic [15:0] fbLevel_r;
  logic [15:0] fbTime_r;
  logic hostExtCmd_r;
  logic [FLT_W-1:0] faultLatch_r;
  logic [FLT_W-1:0] faultPrev_r;
  logic [FLT_W-1:0] irqStatus_r;
  logic [FLT_W-1:0] irqMask_r;
  logic [FLT_W-1:0] faultRaw;
  logic [DIV_W-1:0] divCount_r;
  logic tick;
  logic ack_r;
  logic [31:0] readData_r;
  logic wrAccept;
  logic [31:0] wrMask;
  logic panelUp_r;
  logic faultActive_r;
  logic [4:0] faultCode_r;
  logic motorStop_r;
  logic displayLit_r;
  logic [2:0] ctlMode;
  logic [1:0] devAction;
  logic [1:0] hostAction;
  logic [1:0] fbAction;
  logic [1:0] extSel;
  logic encMode;
  logic safeStopOpen;
  logic [7:0] termFault;
  logic [63:0] termFunc;
  logic panelErr;
  logic [4:0] codeNxt;

  // Setting fields.
  assign ctlMode = modeCfg_r[CFG_MODE_LSB +: 3];
  assign devAction = modeCfg_r[CFG_DEV_ACT_LSB +: 2];
  assign hostAction = modeCfg_r[CFG_HOST_ACT_LSB +: 2];
  assign fbAction = modeCfg_r[CFG_FB_ACT_LSB +: 2];
  assign extSel = modeCfg_r[CFG_EXT_SEL_LSB +: 2];
  assign termFunc = {termFuncHi_r, termFuncLo_r};

  // Millisecond enable; one divider keeps every window on the single core clock.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      divCount_r <= '0;
    end else if (divCount_r >= DIV_W'(TICK_DIV - 1)) begin
      divCount_r <= '0;
    end else begin
      divCount_r <= divCount_r + 1'b1;
    end
  end
  assign tick = (divCount_r >= DIV_W'(TICK_DIV - 1));

  // Bus handshake: one wait state, read data registered at the same edge.
  assign avs_waitrequest = (avs_read || avs_write) && !ack_r;
  assign wrAccept = avs_write && ack_r;
  assign avs_readdata = readData_r;
  assign wrMask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}}, {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= (avs_read || avs_write) && !ack_r;
    end
  end

  // Read mux; unmapped offsets answer zero.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      readData_r <= 32'h00000000;
    end else if (avs_read && !ack_r) begin
      case (avs_address)
        OFS_MODE_CFG: readData_r <= modeCfg_r;
        OFS_TERM_FUNC_LO: readData_r <= termFuncLo_r;
        OFS_TERM_FUNC_HI: readData_r <= termFuncHi_r;
        OFS_ENC_TIME: readData_r <= {16'h0000, encTime_r};
        OFS_DEV_LEVEL: readData_r <= {16'h0000, devLevel_r};
        OFS_DEV_TIME: readData_r <= {16'h0000, devTime_r};
        OFS_HOST_TIME: readData_r <= {16'h0000, hostTime_r};
        OFS_FB_LEVEL: readData_r <= {16'h0000, fbLevel_r};
        OFS_FB_TIME: readData_r <= {16'h0000, fbTime_r};
        OFS_HOST_CMD: readData_r <= 32'(hostExtCmd_r) << HOST_CMD_EXT_BIT;
        OFS_FAULT_STATUS: readData_r <= {8'h00, faultLatch_r};
        OFS_IRQ_STATUS: readData_r <= {8'h00, irqStatus_r};
        OFS_IRQ_MASK: readData_r <= {8'h00, irqMask_r};
        default: readData_r <= 32'h00000000;
      endcase
    end
  end

  // Configuration registers honour byte enables.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      modeCfg_r <= RST_MODE_CFG;
      termFuncLo_r <= RST_TERM_FUNC;
      termFuncHi_r <= RST_TERM_FUNC;
    end else if (wrAccept) begin
      case (avs_address)
        OFS_MODE_CFG: modeCfg_r <= ((modeCfg_r & ~wrMask) | (avs_writedata & wrMask)) & CFG_MASK;
        OFS_TERM_FUNC_LO: termFuncLo_r <= (termFuncLo_r & ~wrMask) | (avs_writedata & wrMask);
        OFS_TERM_FUNC_HI: termFuncHi_r <= (termFuncHi_r & ~wrMask) | (avs_writedata & wrMask);
        default: ;
      endcase
    end
  end

  // Level and window settings, low half-word only.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      encTime_r <= RST_ENC_TIME;
      devLevel_r <= RST_DEV_LEVEL;
      devTime_r <= RST_DEV_TIME;
      hostTime_r <= RST_HOST_TIME;
      fbLevel_r <= RST_FB_LEVEL;
      fbTime_r <= RST_FB_TIME;
    end else if (wrAccept) begin
      case (avs_address)
        OFS_ENC_TIME: encTime_r <= (encTime_r & ~wrMask[15:0]) | (avs_writedata[15:0] & wrMask[15:0]);
        OFS_DEV_LEVEL: devLevel_r <= (devLevel_r & ~wrMask[15:0]) | (avs_writedata[15:0] & wrMask[15:0]);
        OFS_DEV_TIME: devTime_r <= (devTime_r & ~wrMask[15:0]) | (avs_writedata[15:0] & wrMask[15:0]);
        OFS_HOST_TIME: hostTime_r <= (hostTime_r & ~wrMask[15:0]) | (avs_writedata[15:0] & wrMask[15:0]);
        OFS_FB_LEVEL: fbLevel_r <= (fbLevel_r & ~wrMask[15:0]) | (avs_writedata[15:0] & wrMask[15:0]);
        OFS_FB_TIME: fbTime_r <= (fbTime_r & ~wrMask[15:0]) | (avs_writedata[15:0] & wrMask[15:0]);
        default: ;
      endcase
    end
  end

  // host command bit
  // The bit holds until the host writes it back to zero.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      hostExtCmd_r <= 1'b0;
    end else if (wrAccept && (avs_address == OFS_HOST_CMD) && avs_byteenable[0]) begin
      hostExtCmd_r <= avs_writedata[HOST_CMD_EXT_BIT];
    end
  end

  assign encMode = (ctlMode == MODE_VF_ENC) || (ctlMode == MODE_SV_A) || (ctlMode == MODE_SV_B);

  // Detection windows, one timer each.
  dfs_timer_if #(.W(16)) encWin();
  dfs_timer_if #(.W(16)) devWin();
  dfs_timer_if #(.W(16)) hostWin();
  dfs_timer_if #(.W(16)) fbWin();
  dfs_timer_if #(.W(16)) panelStartWin();
  dfs_timer_if #(.W(16)) panelLossWin();

  assign encWin.cond = encMode && !encoderPulse;
  assign encWin.limit = encTime_r;
  assign devWin.cond = encMode && (devAction <= 2'h1) && (speedValue > devLevel_r);
  assign devWin.limit = devTime_r;
  assign hostWin.cond = (hostAction <= HOST_ACT_MAX) && !hostFrameValid;
  assign hostWin.limit = hostTime_r;
  assign fbWin.cond = (fbAction == FB_ACT_FAULT) && (feedbackValue < fbLevel_r);
  assign fbWin.limit = fbTime_r;
  assign panelStartWin.cond = !panelUp_r && !panelRxValid;
  assign panelStartWin.limit = 16'(PANEL_START);
  assign panelLossWin.cond = panelUp_r && !panelRxValid;
  assign panelLossWin.limit = 16'(PANEL_LOSS);

  dfs_window_timer #(.W(16), .STRICT(1'b0)) encTimer (
    .core_clk(core_clk), .resetn(resetn), .tick(tick), .win(encWin.timer));
  dfs_window_timer #(.W(16), .STRICT(1'b1)) devTimer (
    .core_clk(core_clk), .resetn(resetn), .tick(tick), .win(devWin.timer));
  dfs_window_timer #(.W(16), .STRICT(1'b0)) hostTimer (
    .core_clk(core_clk), .resetn(resetn), .tick(tick), .win(hostWin.timer));
  dfs_window_timer #(.W(16), .STRICT(1'b0)) fbTimer (
    .core_clk(core_clk), .resetn(resetn), .tick(tick), .win(fbWin.timer));
  dfs_window_timer #(.W(16), .STRICT(1'b0)) panelStartTimer (
    .core_clk(core_clk), .resetn(resetn), .tick(tick), .win(panelStartWin.timer));
  dfs_window_timer #(.W(16), .STRICT(1'b1)) panelLossTimer (
    .core_clk(core_clk), .resetn(resetn), .tick(tick), .win(panelLossWin.timer));

  // The panel counts as established from its first frame until the next reset.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      panelUp_r <= 1'b0;
    end else if (panelRxValid) begin
      panelUp_r <= 1'b1;
    end
  end

  always_comb begin
    safeStopOpen = 1'b0;
    termFault = 8'h00;
    for (int i = 0; i < 8; i++) begin
      if ((termFunc[8*i +: 8] == FUNC_SAFE_STOP) && terminalIn[i]) begin
        safeStopOpen = 1'b1;
      end
      termFault[i] = (termFunc[8*i +: 8] == FUNC_EXT_FAULT) && terminalIn[i] && (extSel <= 2'h1);
    end
  end

  // Present causes, one per fault bit.
  always_comb begin
    faultRaw = '0;
    faultRaw[FLT_ENC] = encWin.expired;
    faultRaw[FLT_DEV] = devWin.expired;
    faultRaw[FLT_HOST] = hostWin.expired;
    faultRaw[FLT_FB] = fbWin.expired;
    faultRaw[FLT_STO] = !safetyInputA || !safetyInputB;
    faultRaw[FLT_SAFE_STOP] = !modeCfg_r[CFG_SAFE_STOP_BIT] && safeStopOpen;
    faultRaw[FLT_HOST_EXT] = hostExtCmd_r;
    faultRaw[FLT_PANEL_START] = panelStartWin.expired;
    faultRaw[FLT_PANEL_LOSS] = panelLossWin.expired;
    faultRaw[FLT_TERM_LSB +: 8] = termFault;
  end

  // latch until reset
  // A reset command only drops bits whose cause is gone; a live cause keeps its bit.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      faultLatch_r <= '0;
    end else if (wrAccept && (avs_address == OFS_FAULT_RESET) && avs_byteenable[0]
                 && avs_writedata[FAULT_RESET_BIT]) begin
      faultLatch_r <= faultRaw;
    end else begin
      faultLatch_r <= faultLatch_r | faultRaw;
    end
  end

  // Interrupt status marks each new fault; a new event wins over a clearing write.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      faultPrev_r <= '0;
      irqStatus_r <= '0;
    end else begin
      faultPrev_r <= faultLatch_r;
      if (wrAccept && (avs_address == OFS_IRQ_STATUS)) begin
        irqStatus_r <= (irqStatus_r & ~(avs_writedata[FLT_W-1:0] & wrMask[FLT_W-1:0]))
                       | (faultLatch_r & ~faultPrev_r);
      end else begin
        irqStatus_r <= irqStatus_r | (faultLatch_r & ~faultPrev_r);
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      irqMask_r <= '0;
    end else if (wrAccept && (avs_address == OFS_IRQ_MASK)) begin
      irqMask_r <= ((irqMask_r & ~wrMask[FLT_W-1:0]) | (avs_writedata[FLT_W-1:0] & wrMask[FLT_W-1:0])) & FLT_VALID;
    end
  end

  assign irq = |(irqStatus_r & irqMask_r);

  // Lowest latched fault bit gives the reported code, plus one; zero means healthy.
  always_comb begin
    codeNxt = 5'h00;
    for (int i = FLT_W - 1; i >= 0; i--) begin
      if (faultLatch_r[i]) begin
        codeNxt = 5'(i + 1);
      end
    end
  end

  assign panelErr = faultLatch_r[FLT_PANEL_START] || faultLatch_r[FLT_PANEL_LOSS];

  // LED panel stop
  // An LCD panel error is reported only; the LED panel stays lit and stops the motor.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      faultActive_r <= 1'b0;
      faultCode_r <= 5'h00;
      motorStop_r <= 1'b0;
      displayLit_r <= 1'b1;
    end else begin
      faultActive_r <= |faultLatch_r;
      faultCode_r <= codeNxt;
      motorStop_r <= (|(faultLatch_r & ~(24'(1) << FLT_PANEL_START) & ~(24'(1) << FLT_PANEL_LOSS)))
                     || (panelErr && modeCfg_r[CFG_LED_PANEL_BIT]);
      displayLit_r <= 1'b1;
    end
  end

  assign faultActive = faultActive_r;
  assign faultCode = faultCode_r;
  assign motorStop = motorStop_r;
  assign panelDisplayLit = displayLit_r;
endmodule

//--- testbench/dfs_supervisor_asserts.sv
// Purpose: Port-level checks of the drive fault supervisor.
// Assumes: Sees only the top module ports; one clock domain.
// Notes: Fault latencies allow a few cycles of input and latch staging.
`timescale 1ns/100ps
module dfs_supervisor_asserts
  import dfs_pkg::*;
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic resetn,
  // Register port.
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Fault side.
  input wire logic safetyInputA,
  input wire logic safetyInputB,
  input wire logic faultActive,
  input wire logic [4:0] faultCode,
  input wire logic motorStop,
  input wire logic panelDisplayLit
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // Accepted writes; only the accepting edge may change state.
  logic rstWr;
  logic extWr;
  assign rstWr = avs_write && !avs_waitrequest && avs_address == OFS_FAULT_RESET && avs_writedata[0];
  assign extWr = avs_write && !avs_waitrequest && avs_address == OFS_HOST_CMD && avs_writedata[2] && avs_byteenable[0];
  // At most one wait state, and none while idle.
  property p_wait_one;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("waitrequest held past one cycle");
  property p_idle;
    !(avs_read || avs_write) |-> !avs_waitrequest;
  endproperty
  a_idle: assert property (p_idle) else $error("waitrequest while idle");
  // Unmapped places above the mask register read as zero.
  property p_unmapped;
    avs_read && !avs_waitrequest && avs_address > OFS_IRQ_MASK |-> avs_readdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_sto;
    !(safetyInputA && safetyInputB) |-> ##[1:6] faultActive;
  endproperty
  a_sto: assert property (p_sto) else $error("open interlock without fault");
  property p_ext;
    extWr |-> ##[1:6] faultActive;
  endproperty
  a_ext: assert property (p_ext) else $error("host command bit without fault");
  property p_hold;
    $fell(faultActive) |-> $past(rstWr) || $past(rstWr, 2) || $past(rstWr, 3);
  endproperty
  a_hold: assert property (p_hold) else $error("fault dropped without fault reset");
  property p_code;
    (faultCode != 5'h00) == faultActive;
  endproperty
  a_code: assert property (p_code) else $error("fault code and active disagree");
  property p_stop;
    faultCode inside {[5'h01:5'h07]} |-> motorStop;
  endproperty
  a_stop: assert property (p_stop) else $error("drive fault without motor stop");
  property p_lit;
    panelDisplayLit;
  endproperty
  a_lit: assert property (p_lit) else $error("panel display dark");
endmodule

bind dfs_supervisor dfs_supervisor_asserts i_dfs_supervisor_asserts (
  .core_clk, .resetn, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
  .avs_readdata, .avs_waitrequest, .safetyInputA, .safetyInputB, .faultActive, .faultCode,
  .motorStop, .panelDisplayLit
);

//--- testbench/dfs_partner.sv
// Purpose: Encoder, host link and panel activity sources.
// Assumes: Bench silences a source to model a lost link.
// Notes: Staggered phases keep the three strobes apart.
`timescale 1ns/100ps
module dfs_partner #(
  parameter int PERIOD = 12
) (
  // Clock.
  input wire logic core_clk,
  // Source enables.
  input wire logic encOn,
  input wire logic hostOn,
  input wire logic panelOn,
  // Activity strobes.
  output logic encoderPulse,
  output logic hostFrameValid,
  output logic panelRxValid
);
  int phase_r = 0;
  // The strobes settle at the first edge, while the supervisor is still held in reset.
  // periodic live activity
  always @(posedge core_clk) begin
    phase_r <= (phase_r == PERIOD - 1) ? 0 : phase_r + 1;
    encoderPulse <= encOn && (phase_r == 0);
    hostFrameValid <= hostOn && (phase_r == 3);
    panelRxValid <= panelOn && (phase_r == 6);
  end
endmodule

//--- testbench/dfs_supervisor_tb.sv
// Purpose: Self-checking bench for the drive fault supervisor.
// Assumes: Four cycles a tick and short panel windows.
// Notes: Each trial raises one cause, reads the latched status, then clears it.
`timescale 1ns/100ps
module dfs_supervisor_tb;
  import dfs_pkg::*;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata, q;
  logic avs_waitrequest, encoderPulse, hostFrameValid, panelRxValid;
  logic [15:0] speedValue = 16'h0;
  logic [15:0] feedbackValue = 16'hFFFF;
  logic safetyInputA = 1'b1;
  logic safetyInputB = 1'b1;
  logic [7:0] terminalIn = 8'h0;
  logic encOn = 1'b1;
  logic hostOn = 1'b1;
  logic panelOn = 1'b1;
  logic faultActive, motorStop, panelDisplayLit, irq;
  logic [4:0] faultCode;
  int errors = 0;
  int checked = 0;
  logic [7:0] ofs [8] = '{OFS_ENC_TIME, OFS_DEV_LEVEL, OFS_DEV_TIME, OFS_HOST_TIME, OFS_FB_LEVEL, OFS_FB_TIME,
    OFS_IRQ_MASK, 8'h40};
  logic [31:0] rst [8] = '{32'h3E8, 32'hFFFF, 32'h3E8, 32'h3E8, 32'h0, 32'h3E8, 32'h0, 32'h0};
  // A 100 MHz clock.
  always #5 core_clk = ~core_clk;
  dfs_supervisor #(.TICK_DIV(4), .PANEL_START(20), .PANEL_LOSS(8)) i_dfs_supervisor (.core_clk, .resetn,
    .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .encoderPulse, .speedValue, .hostFrameValid, .feedbackValue, .safetyInputA, .safetyInputB, .terminalIn,
    .panelRxValid, .faultActive, .faultCode, .motorStop, .panelDisplayLit, .irq);
  dfs_partner i_dfs_partner (.core_clk, .encOn, .hostOn, .panelOn, .encoderPulse, .hostFrameValid, .panelRxValid);
  // One register access; the extra idle edge keeps drivers single per step.
  // A hung wait is ended only by the watchdog, which counts it as a mismatch.
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(posedge core_clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge core_clk);
  endtask
  // Compare one value.
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Let a window run out, then read the latched faults.
  task automatic flt(input string nm, input logic [31:0] e);
    repeat (60) @(posedge core_clk);
    acc(1'b0, OFS_FAULT_STATUS, 32'h0);
    chk(nm, e, q);
  endtask
  // The wait lets a restored source clear its raw cause before the reset.
  task automatic clr;
    repeat (16) @(posedge core_clk);
    acc(1'b1, OFS_FAULT_RESET, 32'h1);
    acc(1'b1, OFS_IRQ_STATUS, 32'hFFFFFFFF);
  endtask
  // Raise or remove one fault cause.
  task automatic cause(input int k, input logic on);
    case (k)
      0: encOn <= !on;
      1: speedValue <= on ? 16'h00C8 : 16'h0000;
      2: hostOn <= !on;
      3: feedbackValue <= on ? 16'h0032 : 16'hFFFF;
      default: terminalIn <= on ? 8'h01 << (k - 4) : 8'h00;
    endcase
  endtask
  task automatic trial(input string nm, input logic [31:0] cfg, input int k, input logic [31:0] e);
    acc(1'b1, OFS_MODE_CFG, cfg);
    cause(k, 1'b1);
    flt(nm, e);
    cause(k, 1'b0);
    clr;
  endtask
  // Verdict and end of run.
  task automatic results;
    if (errors == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Watchdog against a hung handshake.
  initial begin
    #200000;
    errors++;
    results;
  end
  // Main sequence.
  initial begin
    repeat (5) @(posedge core_clk);
    resetn <= 1'b1;
    @(posedge core_clk);
    for (int i = 0; i < 8; i++) begin
      acc(1'b0, ofs[i], 32'h0);
      chk("reset value", rst[i], q);
    end
    acc(1'b1, OFS_FAULT_STATUS, 32'hFFFFFFFF);
    flt("status read only", 32'h0);
    safetyInputA <= 1'b0;
    flt("interlock a", 32'h10);
    chk("code", 32'h5, 32'(faultCode));
    chk("stop", 32'h1, 32'(motorStop));
    chk("irq masked", 32'h0, 32'(irq));
    acc(1'b1, OFS_FAULT_RESET, 32'h1);
    flt("held with cause", 32'h10);
    safetyInputA <= 1'b1;
    safetyInputB <= 1'b0;
    clr;
    flt("interlock b", 32'h10);
    safetyInputB <= 1'b1;
    clr;
    flt("released", 32'h0);
    acc(1'b1, OFS_HOST_CMD, 32'h4);
    flt("host command", 32'h40);
    acc(1'b1, OFS_HOST_CMD, 32'h0);
    clr;
    flt("host command off", 32'h0);
    acc(1'b1, OFS_TERM_FUNC_LO, 32'h19191919);
    acc(1'b1, OFS_TERM_FUNC_HI, 32'h19191919);
    for (int i = 0; i < 8; i++) trial("terminal", 32'h0, 4 + i, 32'h10000 << i);
    for (int s = 0; s < 4; s++) trial("ext select", 32'(s << CFG_EXT_SEL_LSB), 4, s < 2 ? 32'h10000 : 32'h0);
    acc(1'b1, OFS_TERM_FUNC_LO, 32'h1919193A);
    for (int s = 0; s < 2; s++) trial("safe stop", 32'(s << CFG_SAFE_STOP_BIT), 4, s == 0 ? 32'h20 : 32'h0);
    acc(1'b1, OFS_ENC_TIME, 32'h5);
    for (int m = 0; m < 5; m++) trial("encoder", 32'(m), 0, (m == 1 || m > 2) ? 32'h1 : 32'h0);
    flt("encoder alive", 32'h0);
    acc(1'b1, OFS_DEV_LEVEL, 32'h64);
    acc(1'b1, OFS_DEV_TIME, 32'h3);
    for (int a = 0; a < 4; a++) trial("deviation", 32'(a << CFG_DEV_ACT_LSB) | 32'h1, 1, a < 2 ? 32'h2 : 32'h0);
    acc(1'b1, OFS_HOST_TIME, 32'h5);
    for (int a = 0; a < 4; a++) trial("host link", 32'(a << CFG_HOST_ACT_LSB), 2, a < 3 ? 32'h4 : 32'h0);
    acc(1'b1, OFS_FB_LEVEL, 32'h64);
    acc(1'b1, OFS_FB_TIME, 32'h5);
    for (int a = 0; a < 4; a++) trial("feedback", 32'(a << CFG_FB_ACT_LSB), 3, a == 2 ? 32'h8 : 32'h0);
    acc(1'b1, OFS_IRQ_MASK, 32'h100);
    panelOn <= 1'b0;
    flt("panel loss", 32'h100);
    chk("panel code", 32'h9, 32'(faultCode));
    chk("lcd no stop", 32'h0, 32'(motorStop));
    chk("irq", 32'h1, 32'(irq));
    acc(1'b1, OFS_MODE_CFG, 32'h100000);
    repeat (4) @(posedge core_clk);
    chk("led stop", 32'h1, 32'(motorStop));
    chk("display lit", 32'h1, 32'(panelDisplayLit));
    panelOn <= 1'b1;
    clr;
    chk("irq cleared", 32'h0, 32'(irq));
    panelOn <= 1'b0;
    resetn <= 1'b0;
    repeat (5) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (60) @(posedge core_clk);
    flt("panel start", 32'h80);
    results;
  end
endmodule
